// ### pkg/sci_lin_pkg.sv
// Package with register map, status layout and carrier types of the serial status block.
package sci_lin_pkg;

   // ==========================================================================
   // Register map
   // ==========================================================================
   localparam logic [2:0] ADDR_STATUS    = 3'h0;
   localparam logic [2:0] ADDR_DATA      = 3'h1;
   localparam logic [2:0] ADDR_CTRL      = 3'h2;
   localparam logic [2:0] ADDR_BAUD      = 3'h3;
   localparam logic [2:0] ADDR_EXTPRE    = 3'h4;
   localparam logic [2:0] ADDR_LINCTRL   = 3'h5;
   localparam logic [2:0] ADDR_IRQ_STAT  = 3'h6;
   localparam logic [2:0] ADDR_IRQ_MASK  = 3'h7;

   // ==========================================================================
   // Status bit positions
   // ==========================================================================
   localparam int BIT_TX_EMPTY  = 7;
   localparam int BIT_TX_DONE   = 6;
   localparam int BIT_RX_READY  = 5;
   localparam int BIT_IDLE      = 4;
   localparam int BIT_HDR_ERR   = 3;

   // Control register 2 bit positions.
   localparam int BIT_TIE       = 7;
   localparam int BIT_TX_DONE_IRQ_ENABLE      = 6;
   localparam int BIT_RIE       = 5;
   localparam int BIT_IDLE_IRQ_ENABLE      = 4;

   // LIN control bit positions.
   localparam int BIT_LIN_MODE  = 0;
   localparam int BIT_AUTO_SYNC = 1;
   localparam int BIT_HDR_DET   = 2;
   localparam int BIT_SYNC_BLK  = 3;
   localparam int BIT_NINE_BIT  = 4;

   // ==========================================================================
   // Reset values and constants
   // ==========================================================================
   localparam logic [7:0] STATUS_RESET   = 8'hC0;
   localparam logic [7:0] CTRL_RESET     = 8'h00;
   localparam logic [7:0] MANT_RESET     = 8'h00;
   localparam logic [3:0] FRAC_RESET     = 4'h0;
   localparam logic [7:0] SYNC_BYTE      = 8'h55;
   localparam logic [7:0] MANT_OFF       = 8'h00;

   // Events from the transceiver core.
   typedef struct packed {
      logic       tx_moved;
      logic       tx_char_done;
      logic       tx_preamble;
      logic       rx_moved;
      logic       idle_seen;
      logic       overrun;
      logic       hdr_timeout;
      logic       sync_valid;
      logic [7:0] sync_byte;
      logic       in_header;
      logic       id_valid;
      logic [8:0] id_char;
   } core_event_type;

   // Register bus request.
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_type;

   typedef enum logic [1:0] {
      CLR_IDLE  = 2'b00,
      CLR_ARMED = 2'b01
   } clr_state_type;

endpackage : sci_lin_pkg

// ### design/sci_lin_status.sv
// Status flags, LIN header error detection and LIN divider registers.
`timescale 1ns/1ps

// Behaviour
// - Invalid LIN header sets header error flag; interrupt when receive enable set.
// - Sync-field block flag must be cleared by software before header error clears.
// - Header error clears by status access then data register read.
// - Auto sync on or off: sync byte other than 55h sets header error.
// - Receive overrun sets header error, in or outside the header.
// - With header detect mode, header timeout also sets header error.
// - Identifier parity checked on two top bits, 8-bit or 9-bit word.
// - Bit 7 sets on buffer move; clears by status access then data write.
// - Bit 6 sets on data character done, not preamble; clears likewise.
// - Bit 5 sets on receive move; clears by status access then data read.
// - Bit 4 sets on idle; not again until receive ready has set.
// - Header error is bit 3, interrupts with receive enable; overrun also sets it.
// - In LIN mode mantissa sits at baud address, fraction at prescaler address.
// - Mantissa 01h..FFh used directly; in LIN mode 00h stops the serial clock.
// - Mantissa reads back as written, fraction as its four low bits; no bit set/clear writes.
// - Fraction register holds four low bits; upper four read zero.
module sci_lin_status
   import sci_lin_pkg::*;
(
   // Clock, reset, enable
   input  wire logic           mclk_i,
   input  wire logic           reset_n_i,
   input  wire logic           clk_en_i,
   // Register port
   input  wire logic [2:0]     addr_i,
   input  wire logic [7:0]     wdata_i,
   input  wire logic           wr_i,
   input  wire logic           rd_i,
   output logic      [7:0]     rdata_o,
   // Transceiver core events
   input  wire core_event_type core_ev_i,
   // Core control outputs
   output logic      [7:0]     mantissa_o,
   output logic      [3:0]     fraction_o,
   output logic                sci_clk_en_o,
   output logic                parity_err_o,
   output logic                irq_o
);

   // ==========================================================================
   // Registers
   // ==========================================================================
   logic [7:0]     status_q;
   logic [7:0]     ctrl_q;
   logic [7:0]     lin_ctrl_q;
   logic [7:0]     baud_q;
   logic [7:0]     extpre_q;
   logic [7:0]     mant_q;
   logic [3:0]     frac_q;
   logic [7:0]     data_q;
   logic [7:0]     irq_stat_q;
   logic [7:0]     irq_mask_q;
   logic           idle_armed_q;
   clr_state_type  clr_q;
   logic [7:0]     armed_q;
   bus_req_type    req;

   assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

   function automatic logic hit(input bus_req_type r, input logic [2:0] a);
      return (r.wr || r.rd) && (r.addr == a);
   endfunction : hit

   // Parity of LIN identifier: P0 = id0^id1^id2^id4, P1 = ~(id1^id3^id4^id5).
   function automatic logic [1:0] lin_parity(input logic [5:0] id);
      return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4]};
   endfunction : lin_parity

   logic lin_mode;
   logic status_acc;
   logic data_rd;
   logic data_wr;
   logic hdr_err_ev;
   logic [7:0] set_ev;
   logic [7:0] clr_ev;

   assign lin_mode   = lin_ctrl_q[BIT_LIN_MODE];
   assign status_acc = hit(req, ADDR_STATUS);
   assign data_rd    = req.rd && (req.addr == ADDR_DATA);
   assign data_wr    = req.wr && (req.addr == ADDR_DATA);

   // ==========================================================================
   // Header error detection
   // ==========================================================================
   always_comb begin
      hdr_err_ev = core_ev_i.overrun;
      if (!lin_ctrl_q[BIT_AUTO_SYNC] && core_ev_i.sync_valid &&
          core_ev_i.sync_byte != SYNC_BYTE) begin
         hdr_err_ev = 1'b1;
      end
      if (lin_ctrl_q[BIT_HDR_DET] && core_ev_i.in_header && core_ev_i.hdr_timeout) begin
         hdr_err_ev = 1'b1;
      end
      if (lin_ctrl_q[BIT_AUTO_SYNC] && core_ev_i.sync_valid &&
          core_ev_i.sync_byte != SYNC_BYTE) begin
         hdr_err_ev = 1'b1;
      end
   end

   always_comb begin
      set_ev = 8'h00;
      set_ev[BIT_TX_EMPTY] = core_ev_i.tx_moved;
      set_ev[BIT_TX_DONE]  = core_ev_i.tx_char_done && !core_ev_i.tx_preamble;
      set_ev[BIT_RX_READY] = core_ev_i.rx_moved;
      set_ev[BIT_IDLE]     = core_ev_i.idle_seen && idle_armed_q;
      set_ev[BIT_HDR_ERR]  = hdr_err_ev;
   end

   // Clear: armed status access followed by the right data access.
   always_comb begin
      clr_ev = 8'h00;
      if (clr_q == CLR_ARMED) begin
         clr_ev[BIT_TX_EMPTY] = data_wr && armed_q[BIT_TX_EMPTY];
         clr_ev[BIT_TX_DONE]  = data_wr && armed_q[BIT_TX_DONE];
         clr_ev[BIT_RX_READY] = data_rd && armed_q[BIT_RX_READY];
         clr_ev[BIT_IDLE]     = data_rd && armed_q[BIT_IDLE];
         clr_ev[BIT_HDR_ERR]  = data_rd && armed_q[BIT_HDR_ERR] &&
                                !lin_ctrl_q[BIT_SYNC_BLK];
      end
   end

   // ==========================================================================
   // Status flags and clear sequencer
   // ==========================================================================
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         status_q <= STATUS_RESET;
      end else if (clk_en_i) begin
         status_q <= (status_q & ~clr_ev) | set_ev;
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         clr_q   <= CLR_IDLE;
         armed_q <= 8'h00;
      end else if (clk_en_i) begin
         if (status_acc && status_q != 8'h00) begin
            clr_q   <= CLR_ARMED;
            armed_q <= status_q;
         end else if (data_rd || data_wr) begin
            clr_q   <= CLR_IDLE;
            armed_q <= 8'h00;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         idle_armed_q <= 1'b1;
      end else if (clk_en_i) begin
         if (core_ev_i.rx_moved) begin
            idle_armed_q <= 1'b1;
         end else if (set_ev[BIT_IDLE]) begin
            idle_armed_q <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // Identifier parity
   // ==========================================================================
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         parity_err_o <= 1'b0;
      end else if (clk_en_i && core_ev_i.id_valid) begin
         if (lin_ctrl_q[BIT_NINE_BIT]) begin
            parity_err_o <= core_ev_i.id_char[8:7] != lin_parity(core_ev_i.id_char[5:0]);
         end else begin
            parity_err_o <= core_ev_i.id_char[7:6] != lin_parity(core_ev_i.id_char[5:0]);
         end
      end
   end

   // ==========================================================================
   // Software registers
   // ==========================================================================
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_q     <= CTRL_RESET;
         lin_ctrl_q <= CTRL_RESET;
         baud_q     <= CTRL_RESET;
         extpre_q   <= CTRL_RESET;
         mant_q     <= MANT_RESET;
         frac_q     <= FRAC_RESET;
         data_q     <= CTRL_RESET;
         irq_mask_q <= CTRL_RESET;
      end else if (clk_en_i && req.wr) begin
         unique case (req.addr)
            ADDR_DATA:     data_q     <= req.wdata;
            ADDR_CTRL:     ctrl_q     <= req.wdata;
            ADDR_LINCTRL:  lin_ctrl_q <= req.wdata;
            ADDR_IRQ_MASK: irq_mask_q <= req.wdata;
            ADDR_BAUD: begin
               if (lin_mode) mant_q <= req.wdata;
               else          baud_q <= req.wdata;
            end
            ADDR_EXTPRE: begin
               if (lin_mode) frac_q <= req.wdata[3:0];
               else          extpre_q <= req.wdata;
            end
            default: ;
         endcase
      end
   end

   // Interrupt status: set by status set event, write one to clear; set wins.
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_stat_q <= 8'h00;
      end else if (clk_en_i) begin
         irq_stat_q <= (irq_stat_q &
                        ~((req.wr && req.addr == ADDR_IRQ_STAT) ? req.wdata : 8'h00))
                       | set_ev;
      end
   end

   logic [7:0] en_vec;
   always_comb begin
      en_vec = 8'h00;
      en_vec[BIT_TX_EMPTY] = ctrl_q[BIT_TIE];
      en_vec[BIT_TX_DONE]  = ctrl_q[BIT_TX_DONE_IRQ_ENABLE];
      en_vec[BIT_RX_READY] = ctrl_q[BIT_RIE];
      en_vec[BIT_IDLE]     = ctrl_q[BIT_IDLE_IRQ_ENABLE];
      en_vec[BIT_HDR_ERR]  = ctrl_q[BIT_RIE];
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_o <= 1'b0;
      end else if (clk_en_i) begin
         irq_o <= |(status_q & en_vec) | |(irq_stat_q & irq_mask_q);
      end
   end

   // ==========================================================================
   // Divider outputs and read port
   // ==========================================================================
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mantissa_o   <= MANT_RESET;
         fraction_o   <= FRAC_RESET;
         sci_clk_en_o <= 1'b0;
      end else if (clk_en_i) begin
         mantissa_o   <= mant_q;
         fraction_o   <= frac_q;
         sci_clk_en_o <= !lin_mode || (mant_q != MANT_OFF);
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_o <= 8'h00;
      end else if (clk_en_i) begin
         rdata_o <= 8'h00;
         if (req.rd) begin
            unique case (req.addr)
               ADDR_STATUS:   rdata_o <= status_q;
               ADDR_DATA:     rdata_o <= data_q;
               ADDR_CTRL:     rdata_o <= ctrl_q;
               ADDR_BAUD:     rdata_o <= lin_mode ? mant_q : baud_q;
               ADDR_EXTPRE:   rdata_o <= lin_mode ? {4'h0, frac_q} : extpre_q;
               ADDR_LINCTRL:  rdata_o <= lin_ctrl_q;
               ADDR_IRQ_STAT: rdata_o <= irq_stat_q;
               ADDR_IRQ_MASK: rdata_o <= irq_mask_q;
               default:       rdata_o <= 8'h00;
            endcase
         end
      end
   end

   // ==========================================================================
   // Assertions
   // ==========================================================================
   tx_done_set_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      clk_en_i && core_ev_i.tx_char_done && !core_ev_i.tx_preamble |=> status_q[BIT_TX_DONE])
      else $error("transmit done not set");
   preamble_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      clk_en_i && core_ev_i.tx_preamble && !status_q[BIT_TX_DONE] && !core_ev_i.tx_char_done
      |=> !status_q[BIT_TX_DONE])
      else $error("transmit done set by preamble");
   sync_err_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      clk_en_i && core_ev_i.sync_valid && core_ev_i.sync_byte != SYNC_BYTE
      |=> status_q[BIT_HDR_ERR])
      else $error("bad sync byte not flagged");
   overrun_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      clk_en_i && core_ev_i.overrun |=> status_q[BIT_HDR_ERR])
      else $error("overrun not flagged");
   hdr_clear_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      $rose(status_q[BIT_HDR_ERR]) ##1 (!status_acc && !(data_rd || data_wr))[*2]
      |=> status_q[BIT_HDR_ERR])
      else $error("header error cleared without sequence");
   blocked_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      lin_ctrl_q[BIT_SYNC_BLK] && status_q[BIT_HDR_ERR] && !hdr_err_ev
      |=> status_q[BIT_HDR_ERR])
      else $error("header error cleared while blocked");
   rx_clear_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      clk_en_i && clr_q == CLR_ARMED && armed_q[BIT_RX_READY] && data_rd && !core_ev_i.rx_moved
      |=> !status_q[BIT_RX_READY])
      else $error("receive ready not cleared");
   clk_off_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      clk_en_i && lin_mode && mant_q == MANT_OFF |=> !sci_clk_en_o)
      else $error("serial clock runs with zero mantissa");
   frac_read_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      clk_en_i && req.rd && req.addr == ADDR_EXTPRE && lin_mode |=> rdata_o[7:4] == 4'h0)
      else $error("fraction upper bits not zero");

   hdr_err_c: cover property (@(posedge mclk_i) $rose(status_q[BIT_HDR_ERR]));
   clear_seq_c: cover property (@(posedge mclk_i) status_acc ##[1:2] data_rd);
   idle_c: cover property (@(posedge mclk_i) $rose(status_q[BIT_IDLE]));

endmodule : sci_lin_status

// ### sim/core_event_model.sv
// Model of the transceiver core that feeds event pulses into the status block.
`timescale 1ns/1ps
module core_event_model
   import sci_lin_pkg::*;
(
   // Clock and reset
   input  wire logic           mclk_i,
   input  wire logic           reset_n_i,
   // Request from the bench
   input  wire core_event_type req_i,
   input  wire logic           req_valid_i,
   // Events towards the block
   output core_event_type      core_ev_o
);
   // ==========================================================================
   // Event pulses
   // ==========================================================================
   // Pulses last one cycle; data fields are scrambled while no event qualifies them.
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         core_ev_o <= '0;
      end else if (req_valid_i) begin
         core_ev_o <= req_i;
      end else begin
         core_ev_o           <= '0;
         core_ev_o.in_header <= core_ev_o.in_header;
         core_ev_o.sync_byte <= ~core_ev_o.sync_byte;
         core_ev_o.id_char   <= ~core_ev_o.id_char;
      end
   end
endmodule : core_event_model

// ### sim/testbench.sv
// Self-checking testbench of the serial status and LIN divider block.
`timescale 1ns/1ps
module testbench;
   import sci_lin_pkg::*;
   logic           mclk_i    = 1'b0;
   logic           reset_n_i = 1'b0;
   logic [2:0]     addr_i    = 3'h0;
   logic [7:0]     wdata_i   = 8'h00;
   logic           wr_i      = 1'b0;
   logic           rd_i      = 1'b0;
   logic           rd_d1     = 1'b0;
   logic           clk_en    = 1'b1;
   logic           req_valid = 1'b0;
   core_event_type req       = '0;
   core_event_type core_ev;
   logic [7:0]     rdata_o;
   logic [7:0]     mantissa_o;
   logic [3:0]     fraction_o;
   logic           sci_clk_en_o;
   logic           parity_err_o;
   logic           irq_o;
   logic [8:0]     exp_q[$];
   logic [31:0]    seed      = 32'hDEDB7BB8;
   int             fails     = 0;
   int             checks    = 0;

   sci_lin_status dut_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .core_ev_i(core_ev), .mantissa_o(mantissa_o), .fraction_o(fraction_o),
      .sci_clk_en_o(sci_clk_en_o), .parity_err_o(parity_err_o), .irq_o(irq_o));
   core_event_model peer_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .req_i(req),
      .req_valid_i(req_valid), .core_ev_o(core_ev));

   always #20 mclk_i = ~mclk_i;

   // ==========================================================================
   // Helpers
   // ==========================================================================
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xs

   function automatic logic [1:0] lin_par(input logic [5:0] d);
      return {~(d[1] ^ d[3] ^ d[4] ^ d[5]), d[0] ^ d[1] ^ d[2] ^ d[4]};
   endfunction : lin_par

   task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, e, g);
      end
   endtask : cmp

   task automatic tally_and_finish;
      $display("checks %0d, fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge mclk_i);
      wr_i    <= 1'b0;
   endtask : wr

   // Bit 8 of the note marks a read whose data is not compared.
   task automatic rd(input logic [2:0] a, input logic [8:0] e);
      exp_q.push_back(e);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge mclk_i);
      rd_i   <= 1'b0;
   endtask : rd

   task automatic ev(input core_event_type e);
      @(posedge mclk_i);
      req       <= e;
      req_valid <= 1'b1;
      @(posedge mclk_i);
      req_valid <= 1'b0;
      repeat (3) @(posedge mclk_i);
   endtask : ev

   task automatic clr(input logic by_read);
      rd(ADDR_STATUS, 9'h100);
      if (by_read) begin
         rd(ADDR_DATA, 9'h100);
      end else begin
         wr(ADDR_DATA, 8'h00);
      end
   endtask : clr

   // Read data stand in the cycle after the strobe; the oldest note is taken then.
   always @(posedge mclk_i) begin
      logic [8:0] n;
      rd_d1 <= rd_i;
      if (rd_d1 && exp_q.size() > 0) begin
         n = exp_q.pop_front();
         if (!n[8]) begin
            cmp("rdata_o", n[7:0], rdata_o);
         end
      end
   end

   initial begin
      #(40 * 20000);
      fails++;
      tally_and_finish();
   end

   // ==========================================================================
   // Tests
   // ==========================================================================
   initial begin
      core_event_type e;
      logic [7:0]     m;
      logic [8:0]     id;
      logic [1:0]     p;
      repeat (2) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      rd(ADDR_STATUS, {1'b0, STATUS_RESET});
      rd(ADDR_BAUD, {1'b0, MANT_RESET});
      cmp("sci_clk_en_o", 8'h01, {7'h00, sci_clk_en_o});
      $display("test reset done");
      clr(1'b0);
      rd(ADDR_STATUS, 9'h000);
      e = '0;
      e.tx_preamble = 1'b1;
      ev(e);
      rd(ADDR_STATUS, 9'h000);
      e = '0;
      e.tx_moved = 1'b1;
      ev(e);
      rd(ADDR_STATUS, 9'h080);
      e = '0;
      e.tx_char_done = 1'b1;
      ev(e);
      rd(ADDR_STATUS, 9'h0C0);
      rd(ADDR_DATA, 9'h100);
      rd(ADDR_STATUS, 9'h0C0);
      clr(1'b0);
      $display("test transmit flags done");
      e = '0;
      e.idle_seen = 1'b1;
      ev(e);
      rd(ADDR_STATUS, 9'h010);
      clr(1'b1);
      ev(e);
      rd(ADDR_STATUS, 9'h000);
      e = '0;
      e.rx_moved = 1'b1;
      ev(e);
      rd(ADDR_STATUS, 9'h020);
      e = '0;
      e.idle_seen = 1'b1;
      ev(e);
      rd(ADDR_STATUS, 9'h030);
      wr(ADDR_DATA, 8'h00);
      rd(ADDR_STATUS, 9'h030);
      clr(1'b1);
      rd(ADDR_STATUS, 9'h000);
      $display("test receive flags done");
      e = '0;
      e.sync_valid = 1'b1;
      e.sync_byte  = SYNC_BYTE;
      ev(e);
      rd(ADDR_STATUS, 9'h000);
      e.sync_byte = SYNC_BYTE ^ 8'h01;
      ev(e);
      rd(ADDR_STATUS, 9'h008);
      clr(1'b1);
      rd(ADDR_STATUS, 9'h000);
      e = '0;
      e.overrun = 1'b1;
      ev(e);
      rd(ADDR_STATUS, 9'h008);
      clr(1'b1);
      e = '0;
      e.hdr_timeout = 1'b1;
      e.in_header   = 1'b1;
      ev(e);
      rd(ADDR_STATUS, 9'h000);
      wr(ADDR_LINCTRL, 8'h04);
      ev(e);
      rd(ADDR_STATUS, 9'h008);
      ev('0);
      clr(1'b1);
      wr(ADDR_LINCTRL, 8'h0A);
      e = '0;
      e.sync_valid = 1'b1;
      e.sync_byte  = 8'hAA;
      ev(e);
      clr(1'b1);
      rd(ADDR_STATUS, 9'h008);
      wr(ADDR_LINCTRL, 8'h02);
      clr(1'b1);
      rd(ADDR_STATUS, 9'h000);
      $display("test header errors done");
      @(posedge mclk_i);
      clk_en <= 1'b0;
      e = '0;
      e.overrun = 1'b1;
      ev(e);
      clk_en <= 1'b1;
      rd(ADDR_STATUS, 9'h000);
      $display("test clock enable done");
      wr(ADDR_IRQ_STAT, 8'hFF);
      wr(ADDR_IRQ_MASK, 8'h00);
      wr(ADDR_CTRL, 8'h20);
      cmp("irq_o", 8'h00, {7'h00, irq_o});
      e = '0;
      e.overrun = 1'b1;
      ev(e);
      cmp("irq_o", 8'h01, {7'h00, irq_o});
      clr(1'b1);
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_IRQ_STAT, 8'hFF);
      wr(ADDR_IRQ_MASK, 8'h08);
      e = '0;
      e.rx_moved = 1'b1;
      ev(e);
      cmp("irq_o", 8'h00, {7'h00, irq_o});
      e = '0;
      e.overrun = 1'b1;
      ev(e);
      cmp("irq_o", 8'h01, {7'h00, irq_o});
      wr(ADDR_IRQ_STAT, 8'h08);
      repeat (2) @(posedge mclk_i);
      cmp("irq_o", 8'h00, {7'h00, irq_o});
      clr(1'b1);
      $display("test interrupt done");
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         id   = seed[8:0];
         p    = lin_par(id[5:0]);
         if (i < 4 && i[0]) id[8:7] = p;
         if (i < 4 && !i[0]) id[7:6] = p;
         wr(ADDR_LINCTRL, i[0] ? 8'h10 : 8'h00);
         e = '0;
         e.id_valid = 1'b1;
         e.id_char  = id;
         ev(e);
         m = {7'h00, i[0] ? (id[8:7] != p) : (id[7:6] != p)};
         cmp("parity_err_o", m, {7'h00, parity_err_o});
      end
      $display("test parity done");
      wr(ADDR_LINCTRL, 8'h01);
      seed = xs(seed);
      m    = seed[7:0] | 8'h01;
      wr(ADDR_BAUD, m);
      rd(ADDR_BAUD, {1'b0, m});
      cmp("mantissa_o", m, mantissa_o);
      cmp("sci_clk_en_o", 8'h01, {7'h00, sci_clk_en_o});
      wr(ADDR_EXTPRE, 8'hFF);
      rd(ADDR_EXTPRE, 9'h00F);
      cmp("fraction_o", 8'h0F, {4'h0, fraction_o});
      wr(ADDR_BAUD, 8'hFF);
      rd(ADDR_BAUD, 9'h0FF);
      wr(ADDR_BAUD, MANT_OFF);
      repeat (2) @(posedge mclk_i);
      cmp("sci_clk_en_o", 8'h00, {7'h00, sci_clk_en_o});
      $display("test divider done");
      repeat (3) @(posedge mclk_i);
      tally_and_finish();
   end
endmodule : testbench
